// ==== hdl/ncp_pkg.sv ====
// package: constants for the non-secure coprocessor permission register
package ncp_pkg;
	// ---------------------------------------------------------------
	// coprocessor move decode
	// ---------------------------------------------------------------
	localparam logic [3:0] NCP_COPROC_NUM = 4'hF;
	localparam logic [2:0] NCP_OPC1 = 3'h0;
	localparam logic [3:0] NCP_CRN = 4'h1;
	localparam logic [3:0] NCP_CRM = 4'h1;
	localparam logic [2:0] NCP_OPC2 = 3'h2;
	localparam logic [3:0] NCP_CRN_PRELOAD = 4'hB;
	localparam logic [3:0] NCP_COPROC_DEBUG = 4'hE;
	localparam logic [3:0] NCP_COPROC_FP_LO = 4'hA;
	localparam logic [3:0] NCP_COPROC_FP_HI = 4'hB;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int NCP_BIT_MP = 18;
	localparam int NCP_BIT_TLB = 17;
	localparam int NCP_BIT_PLE = 16;
	localparam int NCP_BIT_SIMD = 15;
	localparam int NCP_BIT_UPPER = 14;
	localparam int NCP_BIT_COPROC11_NONSECURE_PERMIT = 11;
	localparam int NCP_BIT_COPROC10_NONSECURE_PERMIT = 10;
	// implemented bits, others reserved
	localparam logic [31:0] NCP_IMPL_MASK = 32'h0007_CC00;
	localparam logic [31:0] NCP_RESET_VALUE = 32'h0000_0000;
	// value returned on reserved bits (unknown, fixed here)
	localparam logic [31:0] NCP_RSVD_READ = 32'h0000_0000;
	// processor mode encodings
	localparam logic [4:0] NCP_MODE_USER = 5'h10;
endpackage

// ==== hdl/ncp_cmd_if.sv ====
// interface: decoded coprocessor move carried to the decoder
interface ncp_cmd_if;
	logic valid;
	logic is_write;
	logic [3:0] coproc;
	logic [2:0] opc1;
	logic [3:0] crn;
	logic [3:0] crm;
	logic [2:0] opc2;
	logic hit;
	logic preload_hit;
	modport src (output valid, is_write, coproc, opc1, crn, crm, opc2, input hit, preload_hit);
	modport dec (input valid, is_write, coproc, opc1, crn, crm, opc2, output hit, preload_hit);
endinterface

// ==== hdl/ncp_decode.sv ====
// module: address decode of coprocessor move instructions
module ncp_decode
	import ncp_pkg::*;
(
	ncp_cmd_if.dec cmd
);
	// ---------------------------------------------------------------
	// match this register and the preload group
	// ---------------------------------------------------------------
	always_comb begin
		cmd.hit = cmd.valid && cmd.coproc == NCP_COPROC_NUM && cmd.opc1 == NCP_OPC1 &&
			cmd.crn == NCP_CRN && cmd.crm == NCP_CRM && cmd.opc2 == NCP_OPC2;
		cmd.preload_hit = cmd.valid && cmd.coproc == NCP_COPROC_NUM &&
			cmd.crn == NCP_CRN_PRELOAD;
	end
endmodule

// ==== hdl/ncp_top.sv ====
// module: non-secure coprocessor permission register and its checks
module ncp_top
	import ncp_pkg::*;
#(
	parameter bit HAS_PRELOAD = 1'b1
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cp_valid,
	input wire logic cp_write,
	input wire logic [3:0] cp_coproc,
	input wire logic [2:0] cp_opc1,
	input wire logic [3:0] cp_crn,
	input wire logic [3:0] cp_crm,
	input wire logic [2:0] cp_opc2,
	input wire logic [31:0] cp_wdata,
	input wire logic [4:0] cpu_mode,
	input wire logic nonsecure,
	input wire logic aux_wr,
	input wire logic aux_wdata_mp,
	input wire logic fp_access,
	input wire logic [3:0] fp_coproc,
	input wire logic cpar_simd_disable_in,
	input wire logic cpar_upper_disable_in,
	input wire logic cpar_access_wr,
	output logic [31:0] cp_rdata,
	output logic cp_rvalid,
	output logic cp_undef,
	output logic aux_undef,
	output logic aux_mp_we,
	output logic multiprocessing_bit,
	output logic tlb_lock_allowed,
	output logic fp_undef,
	output logic coproc_access_register_simd_disable,
	output logic coproc_access_register_upper_register_disable,
	output logic cpar_coproc10_nonsecure_permit_we,
	output logic cpar_coproc11_nonsecure_permit_we
);
	logic [31:0] reg_q, reg_d;
	logic [31:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic undef_q, undef_d;
	logic auxu_q, auxu_d;
	logic mp_q, mp_d;
	logic priv;
	logic wr_ok;
	logic [31:0] wmask;
	ncp_cmd_if cmd();

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	assign cmd.valid = cp_valid;
	assign cmd.is_write = cp_write;
	assign cmd.coproc = cp_coproc;
	assign cmd.opc1 = cp_opc1;
	assign cmd.crn = cp_crn;
	assign cmd.crm = cp_crm;
	assign cmd.opc2 = cp_opc2;
	ncp_decode u_dec (
		.cmd(cmd)
	);

	// privilege and write permission
	assign priv = cpu_mode != NCP_MODE_USER;
	assign wr_ok = cmd.hit && cp_write && priv && !nonsecure;
	// writable bits; preload bit dropped when engine absent
	assign wmask = HAS_PRELOAD ? NCP_IMPL_MASK :
		(NCP_IMPL_MASK & ~(32'h1 << NCP_BIT_PLE));

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		reg_d = reg_q;
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		undef_d = 1'b0;
		auxu_d = 1'b0;
		mp_d = mp_q;
		// user mode traps, register untouched
		if (cmd.hit && !priv) begin
			undef_d = 1'b1;
		end else if (wr_ok) begin
			reg_d = cp_wdata & wmask;
		end else if (cmd.hit && !cp_write) begin
			rvalid_d = 1'b1;
			rdata_d = (reg_q & wmask) | (NCP_RSVD_READ & ~NCP_IMPL_MASK);
		end
		// non-secure write to the register itself is ignored
		// preload group trap in non-secure state
		if (cmd.preload_hit && nonsecure && !reg_q[NCP_BIT_PLE]) begin
			undef_d = 1'b1;
		end
		// auxiliary control multiprocessing bit
		if (aux_wr) begin
			if (!nonsecure || reg_q[NCP_BIT_MP]) begin
				mp_d = aux_wdata_mp;
			end else begin
				auxu_d = 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_q <= NCP_RESET_VALUE;
			rdata_q <= 32'h0000_0000;
			rvalid_q <= 1'b0;
			undef_q <= 1'b0;
			auxu_q <= 1'b0;
			mp_q <= 1'b0;
		end else begin
			reg_q <= reg_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			undef_q <= undef_d;
			auxu_q <= auxu_d;
			mp_q <= mp_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign cp_rdata = rdata_q;
	assign cp_rvalid = rvalid_q;
	assign cp_undef = undef_q;
	assign aux_undef = auxu_q;
	assign aux_mp_we = aux_wr && (!nonsecure || reg_q[NCP_BIT_MP]);
	assign multiprocessing_bit = mp_q;
	assign tlb_lock_allowed = !nonsecure || reg_q[NCP_BIT_TLB];
	// floating coprocessor gate; other numbers pass untouched
	always_comb begin
		fp_undef = 1'b0;
		if (fp_access && nonsecure) begin
			if (fp_coproc == NCP_COPROC_FP_LO) begin
				fp_undef = !reg_q[NCP_BIT_COPROC10_NONSECURE_PERMIT];
			end else if (fp_coproc == NCP_COPROC_FP_HI) begin
				fp_undef = !reg_q[NCP_BIT_COPROC11_NONSECURE_PERMIT];
			end else if (fp_coproc == NCP_COPROC_NUM || fp_coproc == NCP_COPROC_DEBUG) begin
				fp_undef = 1'b0;
			end
		end
	end
	assign coproc_access_register_simd_disable =
		cpar_simd_disable_in || (nonsecure && reg_q[NCP_BIT_SIMD]);
	assign coproc_access_register_upper_register_disable =
		cpar_upper_disable_in || (nonsecure && reg_q[NCP_BIT_UPPER]);
	// access field write enables in the coproc access register
	assign cpar_coproc10_nonsecure_permit_we = cpar_access_wr && (!nonsecure || reg_q[NCP_BIT_COPROC10_NONSECURE_PERMIT]);
	assign cpar_coproc11_nonsecure_permit_we = cpar_access_wr && (!nonsecure || reg_q[NCP_BIT_COPROC11_NONSECURE_PERMIT]);
endmodule

// ==== dv/ncp_top_properties.sv ====
// checker: bound properties of the non-secure permission register
module ncp_top_properties
	import ncp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cp_valid,
	input wire logic cp_write,
	input wire logic [3:0] cp_coproc,
	input wire logic [2:0] cp_opc1,
	input wire logic [3:0] cp_crn,
	input wire logic [3:0] cp_crm,
	input wire logic [2:0] cp_opc2,
	input wire logic [31:0] cp_wdata,
	input wire logic [4:0] cpu_mode,
	input wire logic nonsecure,
	input wire logic aux_wr,
	input wire logic aux_wdata_mp,
	input wire logic fp_access,
	input wire logic [3:0] fp_coproc,
	input wire logic [31:0] cp_rdata,
	input wire logic cp_rvalid,
	input wire logic cp_undef,
	input wire logic aux_undef,
	input wire logic aux_mp_we,
	input wire logic multiprocessing_bit,
	input wire logic tlb_lock_allowed,
	input wire logic fp_undef
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [31:0] sh_q;
	logic hit;
	logic priv;
	// register select and privilege
	assign priv = cpu_mode != NCP_MODE_USER;
	assign hit = cp_valid && cp_coproc == NCP_COPROC_NUM && cp_opc1 == NCP_OPC1
		&& cp_crn == NCP_CRN && cp_crm == NCP_CRM && cp_opc2 == NCP_OPC2;
	// shadow copy, only secure privileged writes land
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sh_q <= '0;
		end else if (hit && cp_write && priv && !nonsecure) begin
			sh_q <= cp_wdata & NCP_IMPL_MASK;
		end
	end
	property p_usr; hit && !priv |=> cp_undef && !cp_rvalid; endproperty
	a_usr: assert property (p_usr) else $error("user access not trapped");
	property p_rd; hit && !cp_write && priv |=> cp_rvalid && cp_rdata == $past(sh_q); endproperty
	a_rd: assert property (p_rd) else $error("read value wrong");
	property p_axt; aux_wr && nonsecure && !sh_q[18] |=> aux_undef && $stable(multiprocessing_bit); endproperty
	a_axt: assert property (p_axt) else $error("aux write not trapped");
	property p_axw; aux_wr && nonsecure && sh_q[18] |=> multiprocessing_bit == $past(aux_wdata_mp); endproperty
	a_axw: assert property (p_axw) else $error("aux write lost");
	property p_tlb; nonsecure |-> tlb_lock_allowed == sh_q[NCP_BIT_TLB]; endproperty
	a_tlb: assert property (p_tlb) else $error("tlb permit wrong");
	property p_mpwe; aux_mp_we == (aux_wr && (!nonsecure || sh_q[NCP_BIT_MP])); endproperty
	a_mpwe: assert property (p_mpwe) else $error("aux write enable wrong");
	property p_c11; cp_valid && cp_coproc == NCP_COPROC_NUM && cp_crn == NCP_CRN_PRELOAD
		&& nonsecure && !sh_q[NCP_BIT_PLE] |=> cp_undef; endproperty
	a_c11: assert property (p_c11) else $error("c11 not trapped");
	property p_fp; fp_access && nonsecure && fp_coproc[3:1] == 3'h5 |-> fp_undef != sh_q[fp_coproc]; endproperty
	a_fp: assert property (p_fp) else $error("fp permit wrong");
	property p_dbg; fp_access && fp_coproc == NCP_COPROC_DEBUG |-> !fp_undef; endproperty
	a_dbg: assert property (p_dbg) else $error("debug coproc gated");
endmodule
bind ncp_top ncp_top_properties u_props (.*);

// ==== dv/ncp_top_tb_top.sv ====
// testbench: random and corner stimulus for the permission register
module ncp_top_tb_top
	import ncp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 0, rst = 1, cp_valid = 0, cp_write = 0, nonsecure = 0, aux_wr = 0;
	logic aux_wdata_mp = 0, fp_access = 1, cpar_simd_disable_in = 0, cpar_upper_disable_in = 0;
	logic cpar_access_wr = 0, cp_rvalid, cp_undef, aux_undef, aux_mp_we, multiprocessing_bit;
	logic tlb_lock_allowed, fp_undef, cpar_coproc10_nonsecure_permit_we, cpar_coproc11_nonsecure_permit_we;
	logic coproc_access_register_simd_disable, coproc_access_register_upper_register_disable;
	logic [3:0] cp_coproc = 4'hF, cp_crn = 4'h1, cp_crm = 4'h1, fp_coproc = 4'hE;
	logic [2:0] cp_opc1 = 3'h0, cp_opc2 = 3'h2;
	logic [4:0] cpu_mode = 5'h13;
	logic [31:0] cp_wdata = 32'h0, cp_rdata, rnd = 32'hF, ex = 32'h0;
	int n_mismatch = 0, checks = 0, cyc = 0;
	ncp_top uut (.*);
	always #12.5 core_clk = ~core_clk;
	// xorshift step
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	// one move, answer sampled a cycle later
	task automatic op(input logic w, ns, input logic [4:0] m, input logic [3:0] rn, input logic [31:0] d);
		@(negedge core_clk);
		{cp_valid, cp_write, nonsecure, cpu_mode, cp_crn, cp_wdata} = {1'h1, w, ns, m, rn, d};
		@(negedge core_clk);
		cp_valid = 0;
	endtask
	task automatic aux(input logic v);
		@(negedge core_clk);
		{aux_wr, nonsecure, aux_wdata_mp} = {1'h1, 1'h1, v};
		@(negedge core_clk);
		aux_wr = 0;
	endtask
	task automatic stop_test;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 1000) begin
			n_mismatch++;
			stop_test();
		end
	end
	initial begin
		repeat (6) @(negedge core_clk);
		rst = 0;
		chk("dbg undef", 32'h0, fp_undef);
		op(0, 1, 5'h13, 4'hB, 0);
		chk("c11 trap", 32'h1, cp_undef);
		op(0, 0, 5'h10, 4'h1, 0);
		chk("user rd", 32'h1, {cp_rvalid, cp_undef});
		aux(1);
		chk("aux trap", 32'h1, {multiprocessing_bit, aux_undef});
		op(1, 0, 5'h13, 4'h1, 32'hFFFF_FFFF);
		ex = 32'hFFFF_FFFF & NCP_IMPL_MASK;
		op(1, 0, 5'h10, 4'h1, 0);
		chk("user wr", 32'h1, {cp_rvalid, cp_undef});
		aux(1);
		chk("aux ok", 32'h2, {multiprocessing_bit, aux_undef});
		op(0, 1, 5'h13, 4'hB, 0);
		chk("c11 ok", 32'h0, cp_undef);
		for (int i = 0; i < 40; i++) begin
			rnd = xs(rnd);
			{cpar_simd_disable_in, cpar_upper_disable_in, cpar_access_wr} = rnd[2:0];
			fp_coproc = {3'h5, rnd[3]};
			op(1, rnd[4], 5'h13, 4'h1, rnd);
			ex = rnd[4] ? ex : rnd & NCP_IMPL_MASK;
			op(0, 1, 5'h13, 4'h1, 0);
			chk("rdata", ex, cp_rdata);
			chk("rvalid", 32'h1, cp_rvalid);
			chk("fp undef", !ex[fp_coproc], fp_undef);
			chk("tlb", ex[17], tlb_lock_allowed);
			chk("simd", ex[15] | rnd[2], coproc_access_register_simd_disable);
			chk("upper", ex[14] | rnd[1], coproc_access_register_upper_register_disable);
			chk("we", {2{rnd[0]}} & ex[11:10], {cpar_coproc11_nonsecure_permit_we, cpar_coproc10_nonsecure_permit_we});
		end
		stop_test();
	end
endmodule
